// file: inc/stc_pkg.sv
// Package: register map, field layout and reset values of the time compare and tick block
package stc_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] STC_OFS_CONTROL     = 8'h00;
  localparam logic [7:0] STC_OFS_IRQ_STATUS  = 8'h04;
  localparam logic [7:0] STC_OFS_IRQ_ENABLE  = 8'h08;
  localparam logic [7:0] STC_OFS_CMP_LOW     = 8'h0C;
  localparam logic [7:0] STC_OFS_CMP_HIGH    = 8'h10;
  localparam logic [7:0] STC_OFS_MASK_LOW    = 8'h14;
  localparam logic [7:0] STC_OFS_MASK_HIGH   = 8'h18;
  localparam logic [7:0] STC_OFS_TICK_PERIOD = 8'h1C;
  localparam logic [7:0] STC_OFS_TICK_COUNT  = 8'h20;

  // Address width decoded by the slave
  localparam int STC_ADDR_W = 8;

  // Control register fields
  localparam int STC_CTL_TIME_EN_BIT = 0;
  localparam int STC_CTL_TICK_EN_BIT = 1;

  // Status, enable register fields (same layout)
  localparam int STC_EVT_TIME_BIT = 0;
  localparam int STC_EVT_TICK_BIT = 1;
  localparam int STC_EVT_W        = 2;

  // Documented widths of compare value and tick count
  localparam int STC_CMP_W  = 33;
  localparam int STC_TICK_W = 32;

  // Bit of the compare-high and mask-high registers that holds the top bit
  localparam int STC_HIGH_BIT = 0;

  // Reset values
  localparam logic [31:0] STC_RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  STC_RST_EVT  = 2'h0;
  localparam logic        STC_RST_BIT  = 1'h0;

  // Nominal rate of the system time clock, for reference
  localparam int STC_SYS_CLK_MHZ = 27;

endpackage : stc_pkg

// file: logic/stc_time_compare_tick.sv
// Time compare alarm and periodic tick logic with APB register access
// Contract
// - Set time flag on unmasked compare match
// - Compare top bit in compare-high bit 0
// - Mask one excludes that compare bit
// - Mask split: low 32 bits, high bit 0
// - High registers bits 31-1 read zero
// - Tick flag every count plus one cycles
// - Writing tick count clears tick counter
// - Counter equal count: flag, restart zero
// - Tick counting ignores counter mode setting
// - Tick count 32-bit read/write, resets zero
`timescale 1ns/1ps

module stc_time_compare_tick
  import stc_pkg::*;
#(
  parameter int CMP_W  = STC_CMP_W,
  parameter int TICK_W = STC_TICK_W
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // System time counter, same clock domain
  input  wire logic [CMP_W-1:0]   system_time_counter,
  input  wire logic               system_time_update,
  // System time clock pin, asynchronous to pclk
  input  wire logic               system_time_clock,
  // Interrupt
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Compare is split over one full word and one single bit, so the
  // register layout only serves the documented width
  if (CMP_W != STC_CMP_W) begin : g_bad_cmp_w
    $error("CMP_W must equal the documented compare width");
  end
  // Tick count lives in one bus word
  if (TICK_W < 1 || TICK_W > STC_TICK_W) begin : g_bad_tick_w
    $error("TICK_W must lie between 1 and the documented tick width");
  end
  // Status and enable words carry one bit per event source
  if (STC_EVT_W != STC_EVT_TICK_BIT + 1) begin : g_bad_evt_w
    $error("event vector width does not match the status layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                   time_compare_enable_ff;
  logic                   tick_enable_ff;
  logic [STC_EVT_W-1:0]   status_ff;
  logic [STC_EVT_W-1:0]   irq_enable_ff;
  logic [31:0]            time_compare_low_ff;
  logic                   time_compare_high_ff;
  logic [31:0]            time_compare_mask_low_ff;
  logic                   time_compare_mask_high_ff;
  logic [TICK_W-1:0]      tick_count_field_ff;
  logic [TICK_W-1:0]      tick_counter_ff;
  // Pin synchroniser and edge history
  logic                   sys_clk_meta_ff;
  logic                   sys_clk_sync_ff;
  logic                   sys_clk_prev_ff;
  // Output flops
  logic [31:0]            prdata_ff;
  logic                   irq_ff;

  // Next-state values built in combinational logic
  logic [STC_EVT_W-1:0]   nxt_status;
  logic [TICK_W-1:0]      nxt_tick_counter;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire logic [STC_ADDR_W-1:0] reg_addr = paddr[STC_ADDR_W-1:0];
  wire logic                  addr_hi_zero = (paddr[31:STC_ADDR_W] == '0);
  wire logic                  access = psel & penable;
  wire logic                  wr_en = access & pwrite;

  // Per-register hits
  // Decode uses the full byte address; bits 1..0 must be zero to hit
  wire logic hit_ctl   = addr_hi_zero & (reg_addr == STC_OFS_CONTROL);
  wire logic hit_sts   = addr_hi_zero & (reg_addr == STC_OFS_IRQ_STATUS);
  wire logic hit_ien   = addr_hi_zero & (reg_addr == STC_OFS_IRQ_ENABLE);
  wire logic hit_cmpl  = addr_hi_zero & (reg_addr == STC_OFS_CMP_LOW);
  wire logic hit_cmph  = addr_hi_zero & (reg_addr == STC_OFS_CMP_HIGH);
  wire logic hit_mskl  = addr_hi_zero & (reg_addr == STC_OFS_MASK_LOW);
  wire logic hit_mskh  = addr_hi_zero & (reg_addr == STC_OFS_MASK_HIGH);
  wire logic hit_tper  = addr_hi_zero & (reg_addr == STC_OFS_TICK_PERIOD);
  wire logic hit_tcnt  = addr_hi_zero & (reg_addr == STC_OFS_TICK_COUNT);

  wire logic hit_any = hit_ctl | hit_sts | hit_ien | hit_cmpl | hit_cmph |
                       hit_mskl | hit_mskh | hit_tper | hit_tcnt;

  // Zero wait states; unmapped addresses answer with an error.
  // Every register is a plain flop, so no access ever needs to stall;
  // an error beats a silent ignore when software mistypes an offset.
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // Write strobes per register
  // The live tick counter has no strobe: it is read only
  wire logic wr_ctl  = wr_en & hit_ctl;
  wire logic wr_sts  = wr_en & hit_sts;
  wire logic wr_ien  = wr_en & hit_ien;
  wire logic wr_cmpl = wr_en & hit_cmpl;
  wire logic wr_cmph = wr_en & hit_cmph;
  wire logic wr_mskl = wr_en & hit_mskl;
  wire logic wr_mskh = wr_en & hit_mskh;
  wire logic wr_tper = wr_en & hit_tper;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Control word view
  // Bits above the two enables read as zero and ignore writes
  wire logic [31:0] ctl_word = {30'h0, tick_enable_ff, time_compare_enable_ff};

  wire logic [31:0] cmph_word = {31'h0, time_compare_high_ff};
  wire logic [31:0] mskh_word = {31'h0, time_compare_mask_high_ff};

  // Status and enable words
  wire logic [31:0] sts_word = {{(32-STC_EVT_W){1'b0}}, status_ff};
  wire logic [31:0] ien_word = {{(32-STC_EVT_W){1'b0}}, irq_enable_ff};

  // Tick words zero-extended when TICK_W is narrow
  wire logic [31:0] tper_word = 32'(tick_count_field_ff);
  wire logic [31:0] tcnt_word = 32'(tick_counter_ff);

  // Read mux; unmapped reads return zero
  // Priority order is harmless: the hits are mutually exclusive
  wire logic [31:0] rd_mux =
      hit_ctl  ? ctl_word :
      hit_sts  ? sts_word :
      hit_ien  ? ien_word :
      hit_cmpl ? time_compare_low_ff :
      hit_cmph ? cmph_word :
      hit_mskl ? time_compare_mask_low_ff :
      hit_mskh ? mskh_word :
      hit_tper ? tper_word :
      hit_tcnt ? tcnt_word : STC_RST_WORD;

  // Read word taken from a flop: captured in the setup cycle so it stands
  // through the access phase, and zero at every other time. A status bit
  // or the live tick counter is therefore one cycle old when read; an event
  // landing in the setup cycle shows on the next read instead.
  wire logic        rd_setup   = psel & ~penable & ~pwrite;
  wire logic [31:0] nxt_prdata = rd_setup ? rd_mux : STC_RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= STC_RST_WORD;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control, enable and compare registers

  // Software-owned configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_compare_enable_ff    <= STC_RST_BIT;
      tick_enable_ff            <= STC_RST_BIT;
      irq_enable_ff             <= STC_RST_EVT;
      time_compare_low_ff       <= STC_RST_WORD;
      time_compare_high_ff      <= STC_RST_BIT;
      time_compare_mask_low_ff  <= STC_RST_WORD;
      time_compare_mask_high_ff <= STC_RST_BIT;
    end else begin
      if (wr_ctl) begin
        time_compare_enable_ff <= pwdata[STC_CTL_TIME_EN_BIT];
        tick_enable_ff         <= pwdata[STC_CTL_TICK_EN_BIT];
      end
      if (wr_ien) begin
        irq_enable_ff <= pwdata[STC_EVT_W-1:0];
      end
      if (wr_cmpl) begin
        time_compare_low_ff <= pwdata;
      end
      if (wr_cmph) begin
        time_compare_high_ff <= pwdata[STC_HIGH_BIT];
      end
      if (wr_mskl) begin
        time_compare_mask_low_ff <= pwdata;
      end
      if (wr_mskh) begin
        time_compare_mask_high_ff <= pwdata[STC_HIGH_BIT];
      end
    end
  end

  // Full-width period, no reserved bits when TICK_W is 32
  // Tick count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count_field_ff <= TICK_W'(STC_RST_WORD);
    end else if (wr_tper) begin
      tick_count_field_ff <= pwdata[TICK_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Masked absolute time compare

  // Full compare value and mask as one vector
  // Top bit sits above the low word in both vectors
  wire logic [CMP_W-1:0] absolute_compare_value = {time_compare_high_ff, time_compare_low_ff};
  wire logic [CMP_W-1:0] absolute_compare_mask  = {time_compare_mask_high_ff, time_compare_mask_low_ff};
  logic      [CMP_W-1:0] bit_match;

  for (genvar i = 0; i < CMP_W; i++) begin : g_cmp_bit
    assign bit_match[i] = absolute_compare_mask[i] |
                          (absolute_compare_value[i] == system_time_counter[i]);
  end

  // No shadow copy of the compare and mask words: each write lands at once,
  // so a half-written 33-bit value can match for one update. Software is
  // expected to clear the compare enable around such rewrites.
  // Enabled match event
  wire logic time_event = time_compare_enable_ff & system_time_update & (&bit_match);

  ////////////////////////////////////////////////////////////////////////////
  // System time clock synchroniser

  // Two flops before any logic; third flop only for edge detect.
  // The flops reset low to match the idle pin, so no false edge follows
  // reset while the pin is low; a pin already high at release gives one
  // false edge, which only matters for a tick that cannot be enabled yet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_meta_ff <= STC_RST_BIT;
      sys_clk_sync_ff <= STC_RST_BIT;
      sys_clk_prev_ff <= STC_RST_BIT;
    end else begin
      sys_clk_meta_ff <= system_time_clock;
      sys_clk_sync_ff <= sys_clk_meta_ff;
      sys_clk_prev_ff <= sys_clk_sync_ff;
    end
  end

  // One pulse per system time clock cycle; pin must stay well below pclk/2
  // Faster pins alias and lose edges silently
  wire logic sys_clk_rise = sys_clk_sync_ff & ~sys_clk_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Periodic tick counter

  wire logic tick_hit = (tick_counter_ff == tick_count_field_ff);

  // Edges are seen two to three bus clocks after the pin moves; the delay
  // can differ by one clock between edges, but every edge counts, so the tick period stays exact. The path
  // has no mode input, so no counter-mode setting can stall or redirect it.
  // Tick every count plus one
  // Counts every rising system time clock edge, no mode input
  wire logic tick_event = tick_enable_ff & sys_clk_rise & tick_hit;

  // Counter held at zero while disabled, so enabling starts a full period
  always_comb begin
    nxt_tick_counter = tick_counter_ff;
    // Count write clears counter
    // A write in the same cycle as an edge wins
    if (wr_tper || !tick_enable_ff) begin
      nxt_tick_counter = '0;
    end else if (sys_clk_rise) begin
      if (tick_hit) begin
        nxt_tick_counter = '0;
      end else begin
        nxt_tick_counter = tick_counter_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_counter_ff <= TICK_W'(STC_RST_WORD);
    end else begin
      tick_counter_ff <= nxt_tick_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and interrupt

  // Event vector in status layout
  wire logic [STC_EVT_W-1:0] evt_vec = {tick_event, time_event};
  wire logic [STC_EVT_W-1:0] clr_vec = wr_sts ? pwdata[STC_EVT_W-1:0] : STC_RST_EVT;

  // A clear that meets a new event in one cycle must not lose that event,
  // so the set term is applied after the clear term
  // Sticky until write-one clear; a new event beats the clear
  always_comb begin
    nxt_status = (status_ff & ~clr_vec) | evt_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= STC_RST_EVT;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Enable word as it stands after this edge
  wire logic [STC_EVT_W-1:0] nxt_irq_enable = wr_ien ? pwdata[STC_EVT_W-1:0] : irq_enable_ff;

  // Level interrupt from a flop; built from next-state values so it adds
  // no cycle of delay behind the status and enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= STC_RST_BIT;
    end else begin
      irq_ff <= |(nxt_status & nxt_irq_enable);
    end
  end

  assign irq = irq_ff;

endmodule // stc_time_compare_tick

// file: sim/stc_time_compare_tick_assertions.sv
// Checker for the time compare and tick block ports
`timescale 1ns/1ps
module stc_tick_chk
  import stc_pkg::*;
#(parameter int CMP_W = STC_CMP_W) (
  // Clock, reset and APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Time sources and interrupt
  input wire logic [CMP_W-1:0] system_time_counter,
  input wire logic             system_time_update,
  input wire logic             system_time_clock,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Access decode; hit covers exactly the nine word offsets
  wire acc = psel && penable;
  wire hit = paddr[31:8] == 24'h0 && paddr[1:0] == 2'b0 && paddr[7:0] <= STC_OFS_TICK_COUNT;
  wire irq_wr = acc && pwrite && hit && (paddr[7:0] == STC_OFS_IRQ_STATUS || paddr[7:0] == STC_OFS_IRQ_ENABLE);
  // Pin history, wide enough to cover the design's synchroniser delay
  logic [5:0] pin_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_ff <= 6'h0;
    else pin_ff <= {pin_ff[4:0], system_time_clock};
  end
  wire pin_rise = |(pin_ff[4:0] & ~pin_ff[5:1]);
  ////////////////////////////////////////////////////////////////
  sequence s_rd(a);
    acc && !pwrite && hit && paddr[7:0] == a;
  endsequence
  property p_ready; pready; endproperty
  property p_rd_idle; !(acc && !pwrite) |-> prdata == 32'h0; endproperty
  property p_unmapped; acc && paddr[31:8] != 24'h0 |-> pslverr && prdata == 32'h0; endproperty
  property p_mapped; acc && hit |-> !pslverr; endproperty
  property p_high_zero; s_rd(STC_OFS_CMP_HIGH) or s_rd(STC_OFS_MASK_HIGH) |-> prdata[31:1] == 31'h0; endproperty
  property p_evt_zero; s_rd(STC_OFS_IRQ_STATUS) or s_rd(STC_OFS_CONTROL) |-> prdata[31:2] == 30'h0; endproperty
  property p_irq_rise; $rose(irq) |-> $past(system_time_update) || $past(irq_wr) || pin_rise; endproperty
  property p_irq_fall; $fell(irq) |-> $past(irq_wr); endproperty
  a_ready:     assert property (p_ready) else $error("pready low");
  a_rd_idle:   assert property (p_rd_idle) else $error("prdata not zero outside read");
  a_unmapped:  assert property (p_unmapped) else $error("unmapped access not refused");
  a_mapped:    assert property (p_mapped) else $error("mapped access refused");
  a_high_zero: assert property (p_high_zero) else $error("high register upper bits set");
  a_evt_zero:  assert property (p_evt_zero) else $error("reserved status bits set");
  a_irq_rise:  assert property (p_irq_rise) else $error("irq rose without an event");
  a_irq_fall:  assert property (p_irq_fall) else $error("irq fell without a clear");
endmodule // stc_tick_chk

bind stc_time_compare_tick stc_tick_chk #(.CMP_W(CMP_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .system_time_counter(system_time_counter), .system_time_update(system_time_update),
  .system_time_clock(system_time_clock), .irq(irq));

// file: sim/stc_time_compare_tick_tb_top.sv
// Testbench for the time compare and tick block
`timescale 1ns/1ps
module stc_time_compare_tick_tb_top
  import stc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        system_time_update, system_time_clock;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [32:0] system_time_counter;
  int          n_errors, check_count;
  stc_time_compare_tick dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_time_counter(system_time_counter), .system_time_update(system_time_update),
    .system_time_clock(system_time_clock), .irq(irq));
  ////////////////////////////////////////////////////////////////
  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, {24'h0, a}, d); endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, {24'h0, a}, 32'h0);
    chk(nm, rd, exp);
  endtask
  // Irq sampled mid-cycle so the edge's updates have landed
  task automatic ci(input logic exp); @(negedge pclk); chk("irq", {31'h0, irq}, {31'h0, exp}); endtask
  task automatic upd(input logic [32:0] v);
    @(posedge pclk); system_time_counter <= v; system_time_update <= 1'b1;
    @(posedge pclk); system_time_update <= 1'b0;
  endtask
  // Slow pin edges, well under half the bus clock rate
  task automatic stk(input int k);
    repeat (k) begin
      repeat (4) @(posedge pclk); system_time_clock <= 1'b1;
      repeat (4) @(posedge pclk); system_time_clock <= 1'b0;
    end
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin pclk = 1'b0; forever #4 pclk = ~pclk; end
  initial begin repeat (20000) @(posedge pclk); n_errors++; print_verdict; end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    system_time_counter = 33'h0; system_time_update = 1'b0; system_time_clock = 1'b0;
    n_errors = 0; check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rc("reset", 8'(a), 32'h0);
    apb(1'b0, 32'h0000_0100, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    // Compare left disabled while its values are rewritten
    wr(STC_OFS_CMP_HIGH, 32'hFFFF_FFFF);
    wr(STC_OFS_MASK_HIGH, 32'hFFFF_FFFE);
    wr(STC_OFS_CMP_LOW, 32'h0000_1234);
    wr(STC_OFS_MASK_LOW, 32'h0000_000F);
    rc("cmp_high", STC_OFS_CMP_HIGH, 32'h1);
    rc("mask_high", STC_OFS_MASK_HIGH, 32'h0);
    rc("cmp_low", STC_OFS_CMP_LOW, 32'h0000_1234);
    rc("mask_low", STC_OFS_MASK_LOW, 32'h0000_000F);
    wr(STC_OFS_IRQ_ENABLE, 32'h3);
    upd({1'b1, 32'h0000_1230}); ci(1'b0);
    wr(STC_OFS_CONTROL, 32'h1);
    upd({1'b0, 32'h0000_1230}); ci(1'b0);
    upd({1'b1, 32'h0000_1220}); ci(1'b0);
    upd({1'b1, 32'h0000_123A}); ci(1'b1);
    upd(33'h0); ci(1'b1);
    rc("status", STC_OFS_IRQ_STATUS, 32'h1);
    wr(STC_OFS_IRQ_STATUS, 32'h1); ci(1'b0);
    wr(STC_OFS_CONTROL, 32'h0);
    wr(STC_OFS_MASK_HIGH, 32'h1);
    wr(STC_OFS_CONTROL, 32'h1);
    upd({1'b0, 32'h0000_1235}); ci(1'b1);
    wr(STC_OFS_CONTROL, 32'h0);
    wr(STC_OFS_IRQ_STATUS, 32'h1);
    // Tick count written while the tick is off
    wr(STC_OFS_TICK_PERIOD, 32'h2);
    wr(STC_OFS_CONTROL, 32'h2);
    stk(2); rc("tick_cnt", STC_OFS_TICK_COUNT, 32'h2);
    rc("status", STC_OFS_IRQ_STATUS, 32'h0);
    wr(STC_OFS_TICK_PERIOD, 32'h2);
    rc("tick_cnt", STC_OFS_TICK_COUNT, 32'h0);
    rc("tick_period", STC_OFS_TICK_PERIOD, 32'h2);
    stk(2); rc("status", STC_OFS_IRQ_STATUS, 32'h0);
    stk(1); rc("status", STC_OFS_IRQ_STATUS, 32'h2);
    ci(1'b1);
    rc("tick_cnt", STC_OFS_TICK_COUNT, 32'h0);
    wr(STC_OFS_IRQ_STATUS, 32'h2); ci(1'b0);
    wr(STC_OFS_IRQ_ENABLE, 32'h1);
    stk(3); rc("status", STC_OFS_IRQ_STATUS, 32'h2);
    ci(1'b0);
    print_verdict;
  end
endmodule // stc_time_compare_tick_tb_top
